// ==== inc/pssc_pkg.sv ====
// Notes on behaviour
// - With the horizontal strap low, the first pixel of a line goes to channel 1800 and the order walks down to channel 1.
// - With the horizontal strap high (default), the first pixel goes to channel 1 and the order walks up to channel 1800.
// - With the vertical strap low, the start pulse leaves on output a and the scan-direction output is 1.
// - With the vertical strap high (default), the start pulse leaves on output b and the scan-direction output is 0.
// - The zig-zag strap selects normal column driving when low and zig-zag driving when high (default).
// - Under zig-zag driving the layout strap picks type 0 when low and type 1 when high (default).
// - The two-bit resolution strap picks 1200x1600, 1080x1920, 600x1024 or 1200x1920 (default), and only 1080 mode disables channels 811 to 990.
// - Every colour component is an 8-bit value, 256 grey levels per subpixel.
package pssc_pkg;

    // --------------------------------------------------------------
    // channel geometry
    // --------------------------------------------------------------
    localparam logic [10:0] CHAN_FIRST = 11'h001;
    localparam logic [10:0] CHAN_LAST = 11'h708;      // 1800
    localparam logic [10:0] CHAN_GAP_LO = 11'h32B;    // 811
    localparam logic [10:0] CHAN_GAP_HI = 11'h3DE;    // 990
    localparam int SUBPIX_W = 8;

    // --------------------------------------------------------------
    // strap vector layout and defaults
    // --------------------------------------------------------------
    localparam int STRAP_W = 6;
    localparam int ST_HDIR = 0;
    localparam int ST_VDIR = 1;
    localparam int ST_ZZ = 2;
    localparam int ST_ZZL = 3;
    localparam int ST_RES_LO = 4;
    localparam logic [5:0] STRAP_DEFAULT = 6'h3F;

    // resolution codes
    localparam logic [1:0] RES_1200X1600 = 2'h0;
    localparam logic [1:0] RES_1080X1920 = 2'h1;
    localparam logic [1:0] RES_600X1024 = 2'h2;
    localparam logic [1:0] RES_1200X1920 = 2'h3;

    // --------------------------------------------------------------
    // register map, byte addresses
    // --------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LINE = 8'h08;
    localparam int CTRL_SRC_EN = 0;
    localparam int CTRL_VST_EN = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;

endpackage

// ==== verilog/pssc_sync.sv ====
`timescale 1ns/1ps
// three-stage strap synchroniser; the output moves only once the
// second and third stages agree, which filters single-cycle glitches
module pssc_sync #(
    parameter int W = 6
) (
    input wire logic clk_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // --------------------------------------------------------------
    // stages
    // --------------------------------------------------------------
    // no reset here: the straps must be tracked while reset is held
    always_ff @(posedge clk_in) begin
        s1_r <= async_in;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end

    // per-bit agreement, generated so each strap filters on its own
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk_in) begin
                if (s2_r[i] == s3_r[i]) begin
                    sync_out[i] <= s3_r[i];
                end
            end
        end
    endgenerate

endmodule

// ==== verilog/pssc_top.sv ====
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module pssc_top (
    input wire logic clk_in,
    input wire logic srst_in,
    // strap pins
    input wire logic horiz_shift_dir_in,
    input wire logic vert_scan_dir_in,
    input wire logic zz_drive_sel_in,
    input wire logic zz_layout_sel_in,
    input wire logic [1:0] resolution_sel_in,
    // subpixel stream from the link receiver
    input wire logic line_start_in,
    input wire logic frame_start_in,
    input wire logic pix_valid_in,
    input wire logic [7:0] pix_data_in,
    // source column and gate outputs
    output logic src_we_out,
    output logic [10:0] src_chan_out,
    output logic [7:0] src_data_out,
    output logic vstart_pulse_a_out,
    output logic vstart_pulse_b_out,
    output logic scan_dir_out,
    output logic zz_drive_out,
    output logic zz_layout_out,
    output logic [1:0] resolution_out,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);

    logic [5:0] strap_sync;
    logic [5:0] straps_r;
    logic [1:0] ctrl_r;
    logic [10:0] chan_r;
    logic [10:0] chan_nxt;
    logic line_done_r;
    logic first_r;
    logic first_q;
    logic accept;
    logic fwd;
    logic skip;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [1:0] ctrl_now;
    logic addr_ph;

    // --------------------------------------------------------------
    // strap capture
    // --------------------------------------------------------------
    pssc_sync #(.W(pssc_pkg::STRAP_W)) u_sync (
        .clk_in(clk_in),
        .async_in({resolution_sel_in, zz_layout_sel_in, zz_drive_sel_in,
                   vert_scan_dir_in, horiz_shift_dir_in}),
        .sync_out(strap_sync)
    );

    // follow the pins only while reset is held, then freeze
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            straps_r <= strap_sync;
        end
    end

    assign fwd = straps_r[pssc_pkg::ST_HDIR];
    assign skip = straps_r[pssc_pkg::ST_RES_LO +: 2]
                  == pssc_pkg::RES_1080X1920;

    // --------------------------------------------------------------
    // static mode outputs
    // --------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            scan_dir_out <= 1'b0;
            zz_drive_out <= 1'b0;
            zz_layout_out <= 1'b0;
            resolution_out <= pssc_pkg::RES_1200X1920;
        end else begin
            scan_dir_out <= ~straps_r[pssc_pkg::ST_VDIR];
            zz_drive_out <= straps_r[pssc_pkg::ST_ZZ];
            // layout type only means something under zig-zag driving
            zz_layout_out <= straps_r[pssc_pkg::ST_ZZ]
                             & straps_r[pssc_pkg::ST_ZZL];
            resolution_out <= straps_r[pssc_pkg::ST_RES_LO +: 2];
        end
    end

    // vertical start pulse routed by scan direction
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            vstart_pulse_a_out <= 1'b0;
            vstart_pulse_b_out <= 1'b0;
        end else begin
            vstart_pulse_a_out <= frame_start_in
                                  & ctrl_r[pssc_pkg::CTRL_VST_EN]
                                  & ~straps_r[pssc_pkg::ST_VDIR];
            vstart_pulse_b_out <= frame_start_in
                                  & ctrl_r[pssc_pkg::CTRL_VST_EN]
                                  & straps_r[pssc_pkg::ST_VDIR];
        end
    end

    // --------------------------------------------------------------
    // channel walk
    // --------------------------------------------------------------
    // next channel, hopping over the disabled gap in 1080 mode
    function automatic logic [10:0] step_chan(input logic [10:0] c,
                                              input logic f,
                                              input logic s);
        if (f) begin
            step_chan = (s && c == pssc_pkg::CHAN_GAP_LO - 11'h001)
                        ? pssc_pkg::CHAN_GAP_HI + 11'h001 : c + 11'h001;
        end else begin
            step_chan = (s && c == pssc_pkg::CHAN_GAP_HI + 11'h001)
                        ? pssc_pkg::CHAN_GAP_LO - 11'h001 : c - 11'h001;
        end
    endfunction

    // line start wins over a pixel in the same cycle
    assign accept = pix_valid_in & ~line_start_in & ~line_done_r
                    & ctrl_r[pssc_pkg::CTRL_SRC_EN];
    assign chan_nxt = step_chan(chan_r, fwd, skip);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            chan_r <= pssc_pkg::CHAN_FIRST;
            line_done_r <= 1'b1;
            first_r <= 1'b0;
        end else if (line_start_in) begin
            chan_r <= fwd ? pssc_pkg::CHAN_FIRST
                          : pssc_pkg::CHAN_LAST;
            line_done_r <= 1'b0;
            first_r <= 1'b1;
        end else if (accept) begin
            chan_r <= chan_nxt;
            first_r <= 1'b0;
            // surplus pixels past the last channel are dropped
            line_done_r <= fwd ? (chan_r == pssc_pkg::CHAN_LAST)
                               : (chan_r == pssc_pkg::CHAN_FIRST);
        end
    end

    // registered column write
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            src_we_out <= 1'b0;
            src_chan_out <= pssc_pkg::CHAN_FIRST;
            src_data_out <= 8'h00;
            first_q <= 1'b0;
        end else begin
            src_we_out <= accept;
            first_q <= accept & first_r;
            if (accept) begin
                src_chan_out <= chan_r;
                src_data_out <= pix_data_in;
            end
        end
    end

    // --------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // --------------------------------------------------------------
    assign addr_ph = hsel & htrans[1] & hready;
    // a write still in its data phase is forwarded to a read behind it
    assign ctrl_now = (wr_pend_r && wr_addr_r == pssc_pkg::REG_CTRL)
                      ? hwdata[1:0] : ctrl_r;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            ctrl_r <= pssc_pkg::CTRL_RESET;
        end else begin
            if (hready) begin
                wr_pend_r <= addr_ph & hwrite;
                wr_addr_r <= haddr[7:0];
            end
            if (wr_pend_r && wr_addr_r == pssc_pkg::REG_CTRL) begin
                ctrl_r <= hwdata[1:0];
            end
        end
    end

    // read data is staged during the address phase
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_ph && !hwrite) begin
                case (haddr[7:0])
                    pssc_pkg::REG_CTRL: hrdata <= {30'h0, ctrl_now};
                    pssc_pkg::REG_STATUS: hrdata <= {26'h0, straps_r};
                    pssc_pkg::REG_LINE: hrdata <= {20'h0, line_done_r,
                                                   src_chan_out};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    first_rev_a: assert property (first_q && !fwd |->
        src_chan_out == pssc_pkg::CHAN_LAST)
        else $error("first pixel not on top channel");
    step_fwd_a: assert property (src_we_out && !first_q && fwd && !skip |->
        src_chan_out == $past(src_chan_out) + 11'h001)
        else $error("forward walk skipped a channel");
    vst_a_a: assert property (frame_start_in && ctrl_r[1] && !straps_r[1]
        |=> vstart_pulse_a_out && !vstart_pulse_b_out && scan_dir_out)
        else $error("start pulse a or scan dir wrong");
    vst_b_a: assert property (frame_start_in && ctrl_r[1] && straps_r[1]
        |=> vstart_pulse_b_out && !vstart_pulse_a_out && !scan_dir_out)
        else $error("start pulse b or scan dir wrong");
    zz_mode_a: assert property ($past(!srst_in) |->
        zz_drive_out == straps_r[2])
        else $error("zig-zag mode mismatch");
    zz_layout_a: assert property ($past(!srst_in) && !zz_drive_out |->
        !zz_layout_out)
        else $error("layout type without zig-zag");
    gap_skip_a: assert property (src_we_out && resolution_out == 2'h1 |->
        (src_chan_out < 11'h32B || src_chan_out > 11'h3DE))
        else $error("disabled channel written");
    data_pass_a: assert property (accept |=>
        src_we_out && src_data_out == $past(pix_data_in))
        else $error("subpixel data corrupted");
    strap_hold_a: assert property ($past(!srst_in) |->
        $stable(straps_r))
        else $error("straps changed in operation");

    line_rev_c: cover property (first_q && !fwd);
    gap_hop_c: cover property (src_we_out && skip
        && src_chan_out == 11'h3DF);
    vst_b_c: cover property (vstart_pulse_b_out);

endmodule

// ==== dv/pssc_host_model.sv ====
`timescale 1ns/1ps
// link-side host: one frame start, one line start, then len_in+1
// subpixels; the last one overruns the line and must be refused
module pssc_host_model (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic slow_in,
    input wire logic [10:0] len_in,
    input wire logic [7:0] seed_in,
    output logic frame_start_out,
    output logic line_start_out,
    output logic pix_valid_out,
    output logic [7:0] pix_data_out,
    output logic busy_out
);
    int n = 0;
    logic [1:0] st_r = 2'h0;
    initial {frame_start_out, line_start_out, pix_valid_out} = 3'h0;
    initial pix_data_out = 8'h00;
    assign busy_out = (st_r != 2'h0);
    // no turnaround path exists: the model only ever drives
    always @(posedge clk_in) begin
        frame_start_out <= 1'b0;
        line_start_out <= 1'b0;
        pix_valid_out <= 1'b0;
        pix_data_out <= ~pix_data_out; // idle data toggles, never stale
        case (st_r)
            2'h0: if (go_in) begin
                frame_start_out <= 1'b1;
                st_r <= 2'h1;
            end
            2'h1: begin
                line_start_out <= 1'b1;
                n <= 0;
                st_r <= 2'h2;
            end
            default: if (!(slow_in && $urandom_range(1) == 0)) begin
                pix_valid_out <= 1'b1;
                pix_data_out <= seed_in + 8'(n * 7);
                n <= n + 1;
                if (n == int'(len_in)) st_r <= 2'h0;
            end
        endcase
    end
endmodule

// ==== dv/pssc_top_bench.sv ====
`timescale 1ns/1ps
module pssc_top_bench;
    logic clk_in = 1'b0, srst_in = 1'b1, go = 1'b0, slow = 1'b0, busy;
    logic hd, vd, zz, zl, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic horiz_shift_dir_in = 1'b1, vert_scan_dir_in = 1'b1;
    logic zz_drive_sel_in = 1'b1, zz_layout_sel_in = 1'b1;
    logic [1:0] rs, resolution_sel_in = 2'h3, htrans = 2'h0, res_o;
    logic line_start, frame_start, pix_valid, src_we, pa_o, pb_o;
    logic scan_dir, zz_o, zl_o;
    logic [7:0] pix_data, src_data, seed = 8'h00;
    logic [10:0] src_chan, len = 11'h708, last_ch;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    int failures = 0, total_checks = 0, wcnt = 0, pa = 0, pb = 0, sd;

    always #2.5 clk_in = ~clk_in;

    pssc_top i_pssc_top (.clk_in(clk_in), .srst_in(srst_in),
        .horiz_shift_dir_in(horiz_shift_dir_in),
        .vert_scan_dir_in(vert_scan_dir_in), .zz_drive_sel_in(zz_drive_sel_in),
        .zz_layout_sel_in(zz_layout_sel_in),
        .resolution_sel_in(resolution_sel_in), .line_start_in(line_start),
        .frame_start_in(frame_start), .pix_valid_in(pix_valid),
        .pix_data_in(pix_data), .src_we_out(src_we), .src_chan_out(src_chan),
        .src_data_out(src_data), .vstart_pulse_a_out(pa_o),
        .vstart_pulse_b_out(pb_o), .scan_dir_out(scan_dir),
        .zz_drive_out(zz_o), .zz_layout_out(zl_o), .resolution_out(res_o),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));

    pssc_host_model i_pssc_host_model (.clk_in(clk_in), .go_in(go),
        .slow_in(slow), .len_in(len), .seed_in(seed),
        .frame_start_out(frame_start), .line_start_out(line_start),
        .pix_valid_out(pix_valid), .pix_data_out(pix_data), .busy_out(busy));

    // --------------------------------------------------------------
    // reporting
    // --------------------------------------------------------------
    task automatic give_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // channel of the k-th accepted subpixel; the 1080 gap is skipped
    function automatic logic [10:0] exp_chan(int k);
        int c;
        c = k + 1;
        if (rs == 2'h1 && c > 810) c = c + 180;
        if (hd == 1'b0) c = 1801 - c;
        exp_chan = 11'(c);
    endfunction

    // --------------------------------------------------------------
    // bus and stream tasks
    // --------------------------------------------------------------
    task automatic wait_ready;
        int t;
        t = 0;
        do begin
            @(posedge clk_in);
            t++;
        end while (hreadyout !== 1'b1 && t < 50);
        if (t >= 50) begin
            failures++;
            give_verdict();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk(32'(hresp), 32'h0);
    endtask

    // one frame start and one line from the host, then count results
    task automatic line_pass(input logic on);
        int t;
        wcnt = 0;
        pa = 0;
        pb = 0;
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        @(posedge clk_in);
        t = 0;
        while (busy !== 1'b0 && t < 5000) begin
            @(posedge clk_in);
            t++;
        end
        if (t >= 5000) begin
            failures++;
            give_verdict();
        end
        repeat (4) @(posedge clk_in);
        chk(wcnt, on ? 32'(len) : 32'h0);
        chk(pa, 32'(on & ~vd));
        chk(pb, 32'(on & vd));
    endtask

    // every accepted subpixel checked for channel order and value
    always @(posedge clk_in) begin
        if (src_we === 1'b1) begin
            chk(32'(src_chan), 32'(exp_chan(wcnt)));
            chk(32'(src_data), 32'(8'(seed + 8'(wcnt * 7))));
            wcnt++;
        end
        if (pa_o === 1'b1) pa++;
        if (pb_o === 1'b1) pb++;
    end

    // --------------------------------------------------------------
    // main sequence: every resolution code, both scan directions
    // --------------------------------------------------------------
    initial begin
        sd = $urandom(32'h57DA);
        for (int i = 0; i < 4; i++) begin
            rs = 2'(i);
            {hd, vd, zz, zl} = {rs[0], rs[1], 2'($urandom)};
            len = (rs == 2'h1) ? 11'h654 : 11'h708;
            slow <= 1'($urandom);
            seed <= 8'($urandom);
            srst_in <= 1'b1;
            {resolution_sel_in, zz_layout_sel_in, zz_drive_sel_in,
                vert_scan_dir_in, horiz_shift_dir_in} <= {rs, zl, zz, vd, hd};
            repeat (12) @(posedge clk_in);
            srst_in <= 1'b0;
            @(posedge clk_in);
            // straps wander after release; outputs must not follow
            {resolution_sel_in, zz_layout_sel_in, zz_drive_sel_in,
                vert_scan_dir_in, horiz_shift_dir_in} <= 6'($urandom);
            repeat (3) @(posedge clk_in);
            chk(32'(scan_dir), 32'(!vd));
            chk(32'(zz_o), 32'(zz));
            chk(32'(zl_o), 32'(zz & zl));
            chk(32'(res_o), 32'(rs));
            bus(1'b0, pssc_pkg::REG_STATUS, 32'h0);
            chk(rd, {26'h0, rs, zl, zz, vd, hd});
            bus(1'b0, pssc_pkg::REG_CTRL, 32'h0);
            chk(rd, 32'h00000003);
            bus(1'b0, 8'h0C, 32'h0);
            chk(rd, 32'h00000000);
            line_pass(1'b1);
            // a full line leaves the walk done on its end channel
            bus(1'b0, pssc_pkg::REG_LINE, 32'h0);
            last_ch = hd ? pssc_pkg::CHAN_LAST : pssc_pkg::CHAN_FIRST;
            chk(rd, {20'h0, 1'b1, last_ch});
            bus(1'b1, pssc_pkg::REG_CTRL, 32'h0);
            bus(1'b0, pssc_pkg::REG_CTRL, 32'h0);
            chk(rd, 32'h00000000);
            line_pass(1'b0);
            bus(1'b1, pssc_pkg::REG_CTRL, 32'h3);
        end
        give_verdict();
    end
endmodule
